// [core/mpnau_pkg.sv]
/*
  Constants, enumerations and the jump-function decoder of the
  microprogram next-address unit.
  Assumes one 50 MHz clock and an AXI4-Lite register port.
*/
// How it works
// RULE1 - load puts buses in address, clears bit 8
// RULE2 - primary picks column, secondary picks low row
// RULE3 - zero-row jump to column 15 raises strobe
// RULE4 - microprogram fetch sequence starts row 0, column 15
// RULE5 - interrupt controller disables row, drives own row
// RULE6 - substituted row never changes the address register
// RULE7 - load beats any jump function
// RULE8 - load keeps latch enable, capture, strobe, flags
// RULE9 - same-column jump takes row from control bits
// RULE10 - row-zero, same-row, latch-enable jump layouts
// RULE11 - flag-latch, carry and zero test layouts
// RULE12 - aux-latch and aux-left test layouts
// RULE13 - aux-right and primary-bus test layouts
// RULE14 - flag control bits 1..0 select flag loading
// RULE15 - flag control bits 3..2 select flag output
// RULE16 - capture latch feeds flags at rising edge
// RULE17 - primary-bus test captures secondary bits into latch
// RULE18 - latch-enable jump enables latch pins at once
// RULE19 - address register takes next address each edge; the code holds it while freeze is set
package mpnau_pkg;

  localparam int UADDR_W = 9;
  localparam int ROW_W   = 5;
  localparam int COL_W   = 4;
  localparam int AC_W    = 7;
  localparam int FC_W    = 4;
  localparam int AXI_AW  = 4;
  localparam int AXI_DW  = 32;

  localparam logic [UADDR_W-1:0] UADDR_RESET = 9'h000;
  localparam logic               FLAG_RESET  = 1'b0;
  localparam logic [3:0]         AUX_RESET   = 4'h0;
  localparam logic               FREEZE_RESET = 1'b0;
  localparam logic               LOAD_MSB    = 1'b0;
  localparam logic [COL_W-1:0]   ISE_COL     = 4'hF;

  // register map
  localparam logic [AXI_AW-1:0] REG_CTRL_OFS = 4'h0;
  localparam logic [AXI_AW-1:0] REG_STAT_OFS = 4'h4;
  localparam int CTRL_FREEZE_BIT = 0;
  localparam int STAT_UADDR_LSB  = 0;
  localparam int STAT_CARRY_BIT  = 9;
  localparam int STAT_ZERO_BIT   = 10;
  localparam int STAT_FLATCH_BIT = 11;
  localparam int STAT_AUX_LSB    = 12;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    jump_same_column         = 4'b0000,
    jump_row_zero            = 4'b0001,
    jump_same_row            = 4'b0010,
    jump_column_latch_enable = 4'b0011,
    jump_test_flag_latch     = 4'b0100,
    jump_test_carry          = 4'b0101,
    jump_test_zero           = 4'b0110,
    jump_test_aux_latch      = 4'b0111,
    jump_test_aux_left       = 4'b1000,
    jump_test_aux_right      = 4'b1001,
    jump_test_primary_bus    = 4'b1010
  } mpnau_jump_e;

  typedef enum logic [1:0] {
    set_carry_and_zero = 2'b00,
    set_zero_only      = 2'b01,
    set_carry_only     = 2'b10,
    hold_flags         = 2'b11
  } mpnau_fin_e;

  typedef enum logic [1:0] {
    force_out_low   = 2'b00,
    force_out_carry = 2'b01,
    force_out_zero  = 2'b10,
    force_out_high  = 2'b11
  } mpnau_fout_e;

  // prefix decode of the seven address control bits
  function automatic mpnau_jump_e mpnau_decode(input logic [AC_W-1:0] ac);
    mpnau_jump_e j;
    j = jump_same_column;
    if (ac[6:5] == 2'b00)
      j = jump_same_column;
    else if (ac[6:4] == 3'b010)
      j = jump_row_zero;
    else if (ac[6:4] == 3'b011)
      j = jump_same_row;
    else if (ac[6:4] == 3'b100)
      j = jump_test_flag_latch;
    else if (ac[6:3] == 4'b1010)
      j = jump_test_carry;
    else if (ac[6:3] == 4'b1011)
      j = jump_test_zero;
    else if (ac[6:3] == 4'b1100)
      j = jump_test_aux_latch;
    else if (ac[6:3] == 4'b1101)
      j = jump_test_aux_left;
    else if (ac[6:3] == 4'b1110)
      j = jump_column_latch_enable;
    else if (ac[6:2] == 5'b11111)
      j = jump_test_aux_right;
    else
      j = jump_test_primary_bus;
    return j;
  endfunction : mpnau_decode

endpackage : mpnau_pkg

// [core/mpnau_next_addr.sv]
/*
  Combinational next-address former: eleven jump functions and the load.
  Assumes the caller registers the result and supplies the decoded jump.
*/
`timescale 1ns/10ps
module mpnau_next_addr
  import mpnau_pkg::*;
(
  // current state
  input  wire logic [mpnau_pkg::UADDR_W-1:0] cur,
  input  wire logic [3:0]                    aux,
  input  wire logic                          f_now,
  input  wire logic                          carry,
  input  wire logic                          zero,
  // microinstruction and buses
  input  wire mpnau_pkg::mpnau_jump_e        jump,
  input  wire logic [mpnau_pkg::AC_W-1:0]    ac,
  input  wire logic                          load,
  input  wire logic [7:4]                    px,
  input  wire logic [3:0]                    sx,
  // result
  output logic      [mpnau_pkg::UADDR_W-1:0] next_uaddr
);
  logic [ROW_W-1:0] row;
  logic [COL_W-1:0] col;

  always_comb
  begin
    row = cur[8:4];
    col = cur[3:0];
    case (jump)
      jump_same_column:         row = ac[4:0];                                 // RULE9
      jump_row_zero:            begin row = 5'h00; col = ac[3:0]; end          // RULE10
      jump_same_row:            col = ac[3:0];                                 // RULE10
      jump_column_latch_enable: row = {cur[8:7], ac[2:0]};                     // RULE10
      jump_test_flag_latch:     begin row = {cur[8], ac[3:0]};
                                  col = {cur[3], 2'b01, f_now}; end            // RULE11
      jump_test_carry:          begin row = {cur[8:7], ac[2:0]};
                                  col = {cur[3], 2'b01, carry}; end            // RULE11
      jump_test_zero:           begin row = {cur[8:7], ac[2:0]};
                                  col = {cur[3], 2'b01, zero}; end             // RULE11
      jump_test_aux_latch:      begin row = {cur[8:7], ac[2:0]}; col = aux; end // RULE12
      jump_test_aux_left:       begin row = {cur[8:7], ac[2:0]};
                                  col = {2'b01, aux[3:2]}; end                 // RULE12
      jump_test_aux_right:      begin row = {cur[8:7], 1'b1, ac[1:0]};
                                  col = {2'b11, aux[1:0]}; end                 // RULE13
      jump_test_primary_bus:    begin row = {cur[8:6], ac[1:0]}; col = px; end  // RULE13
      default:                  row = cur[8:4];
    endcase
    if (load)
    begin
      row = {LOAD_MSB, sx};  // RULE1 RULE2 RULE7
      col = px;              // RULE1 RULE2
    end
    next_uaddr = {row, col};
  end

endmodule : mpnau_next_addr

// [core/mpnau_axil.sv]
/*
  AXI4-Lite slave handshake for the unit's small register file.
  Assumes the parent decodes addresses combinationally and holds registers.
*/
`timescale 1ns/10ps
module mpnau_axil
  import mpnau_pkg::*;
(
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          arst_n,
  // write address and data
  input  wire logic [mpnau_pkg::AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [mpnau_pkg::AXI_DW-1:0]  s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // read
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [mpnau_pkg::AXI_DW-1:0]       s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // parent side
  input  wire logic [mpnau_pkg::AXI_DW-1:0]  rd_data,
  input  wire logic                          rd_hit,
  input  wire logic                          wr_hit,
  output logic                               wr_go,
  output logic [mpnau_pkg::AXI_AW-1:0]       wr_addr,
  output logic [mpnau_pkg::AXI_DW-1:0]       wr_data,
  output logic [3:0]                         wr_strb
);
  logic aw_held;
  logic w_held;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  // write fires only once both halves are in; either may come first
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_held <= 1'b0;
      wr_addr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_held <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      w_held  <= 1'b0;
      wr_data <= '0;
      wr_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held  <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end
    else if (wr_go)
      w_held <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? rd_data : '0;
      s_axi_rresp  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : mpnau_axil

// [core/mpnau_top.sv]
/*
  Microprogram next-address unit: address register, flags, aux latch,
  flag output, interrupt strobe enable and AXI4-Lite control/status.
  Assumes inputs synchronous to sys_clk and an outside controller that
  may take over the row lines while row_override_enable_n is low.
*/
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module mpnau_top
  import mpnau_pkg::*;
(
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          arst_n,
  // AXI4-Lite write
  input  wire logic [mpnau_pkg::AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [mpnau_pkg::AXI_DW-1:0]  s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read
  input  wire logic [mpnau_pkg::AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [mpnau_pkg::AXI_DW-1:0]       s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // microinstruction fields and instruction buses
  input  wire logic [mpnau_pkg::AC_W-1:0]    addr_ctrl_in,
  input  wire logic [mpnau_pkg::FC_W-1:0]    flag_ctrl_in,
  input  wire logic                          load_strobe,
  input  wire logic [7:4]                    primary_instr_bus,
  input  wire logic [3:0]                    secondary_instr_bus,
  input  wire logic                          flag_in,
  // microprogram memory address lines
  input  wire logic                          row_override_enable_n,
  output logic [mpnau_pkg::ROW_W-1:0]        uaddr_row_out,
  output logic                               uaddr_row_oe,
  output logic [mpnau_pkg::COL_W-1:0]        uaddr_col_out,
  // latch pins, flag and strobe
  output logic [3:0]                         aux_latch_out,
  output logic                               aux_latch_oe,
  output logic                               flag_out,
  output logic                               irq_strobe_enable_out
);
  logic [UADDR_W-1:0] uaddr_reg;
  logic [UADDR_W-1:0] next_uaddr;
  logic [3:0]         aux_latch;
  logic               carry_flag;
  logic               zero_flag;
  logic               f_latch;
  logic               freeze;
  mpnau_jump_e        jump;
  mpnau_fin_e         fin_sel;
  mpnau_fout_e        fout_sel;
  logic               wr_go;
  logic [AXI_AW-1:0]  wr_addr;
  logic [AXI_DW-1:0]  wr_data;
  logic [3:0]         wr_strb;
  logic [AXI_DW-1:0]  rd_data;
  logic               rd_hit;
  logic               wr_hit;

  assign jump     = mpnau_decode(addr_ctrl_in);
  assign fin_sel  = mpnau_fin_e'(flag_ctrl_in[1:0]);
  assign fout_sel = mpnau_fout_e'(flag_ctrl_in[3:2]);

  mpnau_next_addr u_next
  (
    .cur        (uaddr_reg),
    .aux        (aux_latch),
    .f_now      (flag_in),
    .carry      (carry_flag),
    .zero       (zero_flag),
    .jump       (jump),
    .ac         (addr_ctrl_in),
    .load       (load_strobe),
    .px         (primary_instr_bus),
    .sx         (secondary_instr_bus),
    .next_uaddr (next_uaddr)
  );

  // freeze is a debug hold: it stalls uaddr_reg, aux_latch, carry_flag and zero_flag at once, but not f_latch
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      uaddr_reg <= UADDR_RESET;
    else if (!freeze)
      uaddr_reg <= next_uaddr;  // RULE19 RULE7
  end

  // the outside row never feeds back; jumps keep using uaddr_reg
  assign uaddr_row_out = uaddr_reg[8:4];          // RULE6
  assign uaddr_row_oe  = row_override_enable_n;   // RULE5 RULE6
  assign uaddr_col_out = uaddr_reg[3:0];

  // captured even under a load
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      aux_latch <= AUX_RESET;
    else if (!freeze && jump == jump_test_primary_bus)
      aux_latch <= secondary_instr_bus;  // RULE17 RULE8
  end

  assign aux_latch_out = aux_latch;
  assign aux_latch_oe  = (jump == jump_column_latch_enable);  // RULE18 RULE8

  assign irq_strobe_enable_out = (jump == jump_row_zero)
                               && (addr_ctrl_in[3:0] == ISE_COL);  // RULE3 RULE8

  // transparent-low latch seen at the edge equals flag_in there
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      f_latch <= FLAG_RESET;
    else
      f_latch <= flag_in;  // RULE16
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      carry_flag <= FLAG_RESET;
      zero_flag  <= FLAG_RESET;
    end
    else if (!freeze)
    begin
      case (fin_sel)
        set_carry_and_zero:
        begin
          carry_flag <= flag_in;  // RULE14 RULE16 RULE8
          zero_flag  <= flag_in;  // RULE14 RULE16
        end
        set_zero_only:  zero_flag  <= flag_in;  // RULE14
        set_carry_only: carry_flag <= flag_in;  // RULE14
        hold_flags:     carry_flag <= carry_flag;
        default:        carry_flag <= carry_flag;
      endcase
    end
  end

  always_comb
  begin
    case (fout_sel)
      force_out_low:   flag_out = 1'b0;        // RULE15
      force_out_carry: flag_out = carry_flag;  // RULE15
      force_out_zero:  flag_out = zero_flag;   // RULE15
      force_out_high:  flag_out = 1'b1;        // RULE15
      default:         flag_out = 1'b0;
    endcase
  end

  // control and status registers
  assign wr_hit = (wr_addr == REG_CTRL_OFS) || (wr_addr == REG_STAT_OFS);
  assign rd_hit = (s_axi_araddr == REG_CTRL_OFS) || (s_axi_araddr == REG_STAT_OFS);

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      freeze <= FREEZE_RESET;
    else if (wr_go && wr_addr == REG_CTRL_OFS && wr_strb[0])
      freeze <= wr_data[CTRL_FREEZE_BIT];
  end

  always_comb
  begin
    rd_data = '0;
    if (s_axi_araddr == REG_CTRL_OFS)
      rd_data[CTRL_FREEZE_BIT] = freeze;
    else
    begin
      rd_data[STAT_UADDR_LSB +: UADDR_W] = uaddr_reg;
      rd_data[STAT_CARRY_BIT]            = carry_flag;
      rd_data[STAT_ZERO_BIT]             = zero_flag;
      rd_data[STAT_FLATCH_BIT]           = f_latch;
      rd_data[STAT_AUX_LSB +: 4]         = aux_latch;
    end
  end

  mpnau_axil u_axil
  (
    .sys_clk       (sys_clk),
    .arst_n        (arst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rd_data       (rd_data),
    .rd_hit        (rd_hit),
    .wr_hit        (wr_hit),
    .wr_go         (wr_go),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb)
  );

endmodule : mpnau_top

// [dv/mpnau_mem_model.sv]
/*
  Partner model: microprogram memory address lines and interrupt control.
  Assumes the unit yields its row lines while row_override_enable_n is low.
*/
`timescale 1ns/10ps
module mpnau_mem_model
#(
  parameter logic [4:0] HANDLER_ROW = 5'h15
)
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // request from the bench
  input  wire logic       take_irq,
  // unit address lines and strobe
  input  wire logic [4:0] uaddr_row_out,
  input  wire logic       uaddr_row_oe,
  input  wire logic [3:0] uaddr_col_out,
  input  wire logic       irq_strobe_enable_out,
  // override and resolved lines
  output logic            row_override_enable_n,
  output logic [8:0]      mem_addr
);
  logic [4:0] wire_row;
  // only take an interrupt at a fetch start, where the strobe is up
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      row_override_enable_n <= 1'b1;
    else
      row_override_enable_n <= !(take_irq && irq_strobe_enable_out);
  // undriven row shows the inverse, so a silent unit is caught
  assign wire_row = !row_override_enable_n ? HANDLER_ROW :
                    (uaddr_row_oe ? uaddr_row_out : ~uaddr_row_out);
  assign mem_addr = {wire_row, uaddr_col_out};
endmodule : mpnau_mem_model

// [dv/mpnau_monitor.sv]
/*
  Port checker for the next-address unit.
  Assumes no freeze across load, row-zero, same-column, same-row, primary-bus or carry-load steps.
*/
`timescale 1ns/10ps
module mpnau_monitor
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       arst_n,
  // microinstruction side
  input wire logic [6:0] addr_ctrl_in,
  input wire logic [3:0] flag_ctrl_in,
  input wire logic       load_strobe,
  input wire logic [7:4] primary_instr_bus,
  input wire logic [3:0] secondary_instr_bus,
  input wire logic       flag_in,
  input wire logic       row_override_enable_n,
  // unit outputs
  input wire logic [4:0] uaddr_row_out,
  input wire logic       uaddr_row_oe,
  input wire logic [3:0] uaddr_col_out,
  input wire logic [3:0] aux_latch_out,
  input wire logic       aux_latch_oe,
  input wire logic       flag_out,
  input wire logic       irq_strobe_enable_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  strobe_decode_a: assert property (irq_strobe_enable_out == (addr_ctrl_in == 7'h2F))
    else $error("strobe enable wrong");
  latch_enable_a: assert property (aux_latch_oe == (addr_ctrl_in[6:3] == 4'hE))
    else $error("latch enable wrong");
  load_addr_a: assert property (load_strobe |=> {uaddr_row_out, uaddr_col_out} ==
    {1'b0, $past(secondary_instr_bus), $past(primary_instr_bus)}) else $error("load wrong");
  row_zero_a: assert property (!load_strobe && addr_ctrl_in[6:4] == 3'h2 |=>
    uaddr_row_out == 5'h00 && uaddr_col_out == $past(addr_ctrl_in[3:0]))
    else $error("row zero jump wrong");
  same_column_a: assert property (!load_strobe && addr_ctrl_in[6:5] == 2'h0 |=>
    uaddr_row_out == $past(addr_ctrl_in[4:0]) && $stable(uaddr_col_out))
    else $error("same column jump wrong");
  same_row_a: assert property (!load_strobe && addr_ctrl_in[6:4] == 3'h3 |=>
    $stable(uaddr_row_out) && uaddr_col_out == $past(addr_ctrl_in[3:0]))
    else $error("same row jump wrong");
  aux_capture_a: assert property (addr_ctrl_in[6:2] == 5'h1E |=>
    aux_latch_out == $past(secondary_instr_bus)) else $error("latch capture wrong");
  aux_hold_a: assert property (addr_ctrl_in[6:2] != 5'h1E |=> $stable(aux_latch_out))
    else $error("latch changed");
  flag_load_a: assert property (!flag_ctrl_in[0] ##1 flag_ctrl_in[3:2] == 2'h1 |->
    flag_out == $past(flag_in)) else $error("carry load wrong");
  flag_force_a: assert property (flag_ctrl_in[3] == flag_ctrl_in[2] |->
    flag_out == flag_ctrl_in[3]) else $error("forced flag wrong");
  row_yield_a: assert property (uaddr_row_oe == row_override_enable_n)
    else $error("row enable wrong");
  load_cov: cover property (load_strobe ##1 1'b1);
  strobe_cov: cover property (irq_strobe_enable_out && load_strobe);
  override_cov: cover property (!row_override_enable_n);
endmodule : mpnau_monitor

bind mpnau_top mpnau_monitor u_mon (.*);

// [dv/mpnau_bench.sv]
/*
  Self-checking bench for the next-address unit, with a reference model.
  Assumes the partner model for memory lines and interrupt control.
*/
`timescale 1ns/10ps
module mpnau_bench;
  import mpnau_pkg::*;
  localparam logic [4:0] HROW = 5'h15;
  localparam logic [6:0] CODES [11] = '{7'h1F, 7'h2F, 7'h35, 7'h75, 7'h4A, 7'h53,
                                        7'h5E, 7'h61, 7'h6A, 7'h7D, 7'h7A};
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [6:0]  addr_ctrl_in = 7'h00;
  logic [3:0]  flag_ctrl_in = 4'h3, secondary_instr_bus = 4'h0, uaddr_col_out;
  logic [7:4]  primary_instr_bus = 4'h0;
  logic        load_strobe = 1'b0, flag_in = 1'b0, take_irq = 1'b0;
  logic        row_override_enable_n, uaddr_row_oe, aux_latch_oe, flag_out;
  logic        irq_strobe_enable_out;
  logic [4:0]  uaddr_row_out;
  logic [3:0]  aux_latch_out;
  logic [8:0]  mem_addr;
  // reference state
  logic [8:0]  e_addr = 9'h000;
  logic [3:0]  e_aux = 4'h0;
  logic        e_c = 1'b0, e_z = 1'b0, frz = 1'b0;
  int          errors = 0, check_count = 0;

  mpnau_top uut (.*);
  mpnau_mem_model #(.HANDLER_ROW(HROW)) u_mem (.*);

  always #10 sys_clk = ~sys_clk;

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("Error %0t: %s", $time, m);
    end
  endtask : chk

  function automatic logic [8:0] ref_next(input logic [6:0] a, input logic l);
    logic [8:0] m;
    m = e_addr;
    if (l)
      return {1'b0, secondary_instr_bus, primary_instr_bus};
    casez (a)
      7'b00?????: return {a[4:0], m[3:0]};
      7'b010????: return {5'h00, a[3:0]};
      7'b011????: return {m[8:4], a[3:0]};
      7'b100????: return {m[8], a[3:0], m[3], 2'h1, flag_in};
      7'b1010???: return {m[8:7], a[2:0], m[3], 2'h1, e_c};
      7'b1011???: return {m[8:7], a[2:0], m[3], 2'h1, e_z};
      7'b1100???: return {m[8:7], a[2:0], e_aux};
      7'b1101???: return {m[8:7], a[2:0], 2'h1, e_aux[3:2]};
      7'b1110???: return {m[8:7], a[2:0], m[3:0]};
      7'b11111??: return {m[8:7], 1'b1, a[1:0], 2'h3, e_aux[1:0]};
      default: return {m[8:6], a[1:0], primary_instr_bus};
    endcase
  endfunction : ref_next

  // drives one microinstruction at an edge, checks the previous step's result
  task automatic step(input logic [6:0] a, input logic l, input logic [3:0] f);
    addr_ctrl_in <= a;
    load_strobe <= l;
    flag_ctrl_in <= f;
    #1;
    chk({uaddr_row_out, uaddr_col_out} === e_addr, "address");
    chk(aux_latch_out === e_aux, "aux latch");
    chk(mem_addr === {row_override_enable_n ? e_addr[8:4] : HROW, e_addr[3:0]}, "mem row");
    chk(uaddr_row_oe === row_override_enable_n, "row enable");
    chk(irq_strobe_enable_out === (a == 7'h2F), "strobe");
    chk(aux_latch_oe === (a[6:3] == 4'hE), "latch enable");
    chk(flag_out === (f[3] ? (f[2] | e_z) : (f[2] & e_c)), "flag out");
    if (!frz)
    begin
      e_addr = ref_next(a, l);
      e_c = f[0] ? e_c : flag_in;
      e_z = f[1] ? e_z : flag_in;
      e_aux = (a[6:2] == 5'h1E) ? secondary_instr_bus : e_aux;
    end
    @(posedge sys_clk);
  endtask : step

  // same-column jump to the current row keeps the address still during bus work
  task automatic park;
    step({2'h0, e_addr[8:4]}, 1'b0, 4'h3);
  endtask : park

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge sys_clk);
    while (!s_axi_bvalid && n < 50)
    begin
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      n++;
      @(posedge sys_clk);
    end
    chk(n < 50 && s_axi_bresp === er, "write response");
    if (n >= 50)
      print_verdict;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    while (!s_axi_rvalid && n < 50)
    begin
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      n++;
      @(posedge sys_clk);
    end
    rd = s_axi_rdata;
    chk(n < 50 && s_axi_rresp === er, "read response");
    if (n >= 50)
      print_verdict;
  endtask : axi_rd

  task automatic sc_regs;
    park;
    axi_rd(REG_CTRL_OFS, AXI_OKAY);
    chk(rd === 32'h0, "control reset");
    axi_rd(4'h8, AXI_SLVERR);
    chk(rd === 32'h0, "unmapped read");
    axi_wr(4'hC, 32'h1, AXI_SLVERR);
    axi_wr(REG_STAT_OFS, 32'hFFFF, AXI_OKAY);
    axi_rd(REG_STAT_OFS, AXI_OKAY);
    chk(rd[15:0] === {e_aux, flag_in, e_z, e_c, e_addr}, "status");
    axi_rd(REG_CTRL_OFS, AXI_OKAY);
    chk(rd === 32'h0, "control after bad write");
  endtask : sc_regs

  task automatic sc_load;
    primary_instr_bus <= 4'hA;
    secondary_instr_bus <= 4'hF;
    step(7'h2F, 1'b1, 4'h3);
    primary_instr_bus <= 4'h0;
    secondary_instr_bus <= 4'h5;
    step(7'h7A, 1'b1, 4'h0);
    step(7'h75, 1'b1, 4'h6);
    step(7'h35, 1'b0, 4'h3);
    park;
  endtask : sc_load

  task automatic sc_jumps;
    for (int i = 0; i < 22; i++)
    begin
      primary_instr_bus <= i[3:0];
      secondary_instr_bus <= ~i[4:1];
      flag_in <= i[0] ^ i[2];
      step(CODES[i % 11], 1'b0, i[3:0]);
    end
    park;
  endtask : sc_jumps

  task automatic sc_irq;
    take_irq <= 1'b1;
    step(7'h2F, 1'b0, 4'h3);
    take_irq <= 1'b0;
    step(7'h37, 1'b0, 4'h3);
    step(7'h4C, 1'b0, 4'h3);
    park;
  endtask : sc_irq

  // frozen unit must hold address and zero flag; no latch capture or carry load is driven
  task automatic sc_freeze;
    axi_wr(REG_CTRL_OFS, 32'h1, AXI_OKAY);
    frz = 1'b1;
    axi_rd(REG_CTRL_OFS, AXI_OKAY);
    chk(rd[0] === 1'b1, "freeze readback");
    flag_in <= 1'b1;
    step(7'h4A, 1'b0, 4'h1);
    step(7'h6A, 1'b0, 4'hB);
    park;
    axi_wr(REG_CTRL_OFS, 32'h0, AXI_OKAY);
    frz = 1'b0;
    step(7'h7D, 1'b0, 4'h3);
    park;
  endtask : sc_freeze

  initial
  begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    sc_regs;
    sc_load;
    sc_jumps;
    sc_irq;
    sc_freeze;
    sc_jumps;
    print_verdict;
  end
endmodule : mpnau_bench
